// [logic/scs_clock_switch.sv]
// System clock source selection, switching, sleep and power-up sequencing
// Contract
// - External clock: amplifier off, no start-up wait
// - External clock: output pin gives input/4
// - External clock I/O: pin is port A bit 6
// - Multiplier gives four times the crystal
// - Multiplier only in high-speed mode
// - Mode fixed by three-bit select field
// - Multiplier: hold execution until lock time-out
// - Switching allowed only with fuse programmed 0
// - Select 0 main, 1 secondary oscillator
// - Every reset clears the source select
// - Disallowed: ignore writes, hold select at 0
// - Control bits 7..1 read zero, select bit 0
// - Count eight target edges before using it
// - Freeze at first quarter, resume after eight
// - Back to crystal: wait start-up time too
// - Back to multiplier: start-up plus lock time
// - Back to RC/external: eight main edges only
// - Sleep stops clocks, core held at Q1
// - Wake on external reset, watchdog, interrupt
// - Power-up timer on POR/BOR; start-up timer
// - Multiplier power-up: delay, timer, start-up, lock
// - Sleep pin states per oscillator mode
// - Start-up timer counts 1024 input edges
// - Power-up timer is 72 ms
`timescale 1ns/100ps

module scs_clock_switch #(
   parameter int POWERUP_TIMER_CYCLES = scs_pkg::POWERUP_TIMER_CYC,  // Power-up timer cycles
   parameter int PLL_CYCLES  = scs_pkg::LOCK_TIME_OUT_CYC,  // Lock time-out cycles
   parameter int CNT_W       = 20                  // Sequencer counter width
) (
   input  wire logic        clk,                  // 10 MHz clock
   input  wire logic        resetn,               // Sync reset, low
   input  wire logic [11:0] paddr,                // APB address
   input  wire logic        psel,                 // APB select
   input  wire logic        penable,              // APB enable
   input  wire logic        pwrite,               // APB write
   input  wire logic [31:0] pwdata,               // APB write data
   output logic      [31:0] prdata,               // APB read data
   output logic             pready,               // APB ready
   output logic             pslverr,              // APB error
   input  wire logic [2:0]  oscSelectField,       // Oscillator mode field
   input  wire logic        switchEnableFuseN,    // 0 enables switching
   input  wire logic        powerupTimerEnFuseN,  // 0 enables power-up timer
   input  wire logic        porEvent,             // Power-on reset pulse
   input  wire logic        borEvent,             // Brown-out reset pulse
   input  wire logic        extResetReq,          // External reset pulse
   input  wire logic        wdtResetReq,          // Watchdog reset pulse
   input  wire logic        wakeIrq,              // Wake interrupt
   input  wire logic        sleepReq,             // Sleep instruction
   input  wire logic        clockInputPin,        // Main clock input level
   input  wire logic        secOscPin,            // Secondary osc level
   input  wire logic        portABitSixOut,       // Port data for pin
   input  wire logic        portABitSixOe,        // Port enable for pin
   output logic             portABitSixIn,        // Pin level to port
   input  wire logic        clockOutputPinIn,     // Clock output pin in
   output logic             clockOutputPinOut,    // Clock output pin out
   output logic             clockOutputPinOe,     // Clock output pin drive
   output logic             coreRun,              // Execution allowed
   output logic             sysClkSel,            // 1 = secondary source
   output logic      [1:0]  quarterPhase,         // Instruction quarter
   output logic             pllEnable,            // Multiplier on
   output logic      [2:0]  clockRatio,           // Internal/input ratio
   output logic             feedbackAmpEn,        // Crystal amplifier on
   output logic             oscRunning            // Main oscillator on
);
   import scs_pkg::*;

   // ****************************************
   // Mode decode
   // ****************************************
   logic xtalMode;
   logic hs4Mode;
   logic ioMode;
   logic plainOut;

   // Crystal, multiplier and pin modes from the field
   assign xtalMode = (oscSelectField == OSC_LP) || (oscSelectField == OSC_XT) ||
                     (oscSelectField == OSC_HS) || (oscSelectField == OSC_HS4);
   assign hs4Mode  = (oscSelectField == OSC_HS4);
   assign ioMode   = (oscSelectField == OSC_EXTERNAL_CLOCK_IO_MODE) || (oscSelectField == OSC_RESISTOR_CAPACITOR_IO_MODE);
   assign plainOut = (oscSelectField == OSC_EC) || (oscSelectField == OSC_RC);

   // ****************************************
   // Edge synchronisers
   // ****************************************
   logic [2:0] mainSync_ff;
   logic [2:0] secSync_ff;
   logic       mainEdge;
   logic       secEdge;

   // Two stages then an edge stage per source
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mainSync_ff <= 3'h0;
         secSync_ff  <= 3'h0;
      end else begin
         mainSync_ff <= {mainSync_ff[1:0], clockInputPin};
         secSync_ff  <= {secSync_ff[1:0], secOscPin};
      end
   end

   assign mainEdge = mainSync_ff[1] & ~mainSync_ff[2];
   assign secEdge  = secSync_ff[1] & ~secSync_ff[2];

   // ****************************************
   // Register interface
   // ****************************************
   logic       noRst;
   logic       anyRst;
   logic       swAllowed;
   logic       apbWr;
   logic       scs_ff;
   logic       secOscEn_ff;
   logic [31:0] prdata_ff;
   logic       mapped;
   scs_state_e state_ff;

   assign noRst     = !porEvent && !borEvent && !extResetReq && !wdtResetReq;
   assign anyRst    = !resetn || !noRst;
   assign swAllowed = !switchEnableFuseN && secOscEn_ff;
   assign apbWr     = psel && penable && pwrite;
   assign mapped    = (paddr == OSC_CTRL_OFS) || (paddr == TMR_CTRL_OFS) ||
                      (paddr == STATUS_OFS);
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !mapped;
   assign prdata    = prdata_ff;

   // Clock source select bit
   always_ff @(posedge clk) begin
      if (anyRst) begin
         scs_ff <= OSC_CTRL_RST[SCS_BIT];
      end else if (!swAllowed) begin
         scs_ff <= 1'b0;
      end else if (apbWr && paddr == OSC_CTRL_OFS) begin
         scs_ff <= pwdata[SCS_BIT];
      end
   end

   // Secondary oscillator enable
   always_ff @(posedge clk) begin
      if (!resetn || porEvent || borEvent) begin
         secOscEn_ff <= 1'b0;
      end else if (apbWr && paddr == TMR_CTRL_OFS) begin
         secOscEn_ff <= pwdata[SECEN_BIT];
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_ff <= 32'h0000_0000;
         unique case (paddr)
            OSC_CTRL_OFS: prdata_ff[SCS_BIT] <= scs_ff;
            TMR_CTRL_OFS: prdata_ff[SECEN_BIT] <= secOscEn_ff;
            STATUS_OFS: prdata_ff[7:0] <= {quarterPhase, oscRunning, pllEnable,
                                           state_ff == ST_SYNC, state_ff == ST_SLEEP,
                                           sysClkSel, coreRun};
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] lim;
   logic             tick;
   logic             cntDone;
   logic             swBack_ff;
   logic             tgt_ff;
   logic             sel_ff;
   logic [1:0]       phase_ff;
   logic             tgtEdge;
   logic             sysEdge;
   logic             atQ1;
   logic             sleeping;

   assign sysEdge  = sel_ff ? secEdge : mainEdge;
   assign tgtEdge  = tgt_ff ? secEdge : mainEdge;
   assign atQ1     = (phase_ff == 2'h0);
   assign sleeping = (state_ff == ST_SLEEP);

   // Count source and limit of each timed state
   always_comb begin
      tick = 1'b0;
      lim  = CNT_W'(1);
      unique case (state_ff)
         ST_PORDLY: begin
            tick = 1'b1;
            lim  = CNT_W'(POR_DLY_CYC);
         end
         ST_POWERUP_TIMER: begin
            tick = 1'b1;
            lim  = CNT_W'(POWERUP_TIMER_CYCLES);
         end
         ST_OST: begin
            tick = mainEdge;
            lim  = CNT_W'(OST_EDGES);
         end
         ST_PLL: begin
            tick = 1'b1;
            lim  = CNT_W'(PLL_CYCLES);
         end
         ST_SYNC: begin
            tick = tgtEdge;
            lim  = CNT_W'(SYNC_EDGES);
         end
         ST_RUN, ST_SLEEP: begin
            tick = 1'b0;
            lim  = CNT_W'(1);
         end
      endcase
   end

   assign cntDone = tick && (cnt_ff == lim - CNT_W'(1));

   // Timer counter
   always_ff @(posedge clk) begin
      if (anyRst || cntDone) begin
         cnt_ff <= '0;
      end else if (tick) begin
         cnt_ff <= cnt_ff + CNT_W'(1);
      end
   end

   // State, target and active source
   always_ff @(posedge clk) begin
      if (!resetn || porEvent || borEvent) begin
         state_ff  <= ST_PORDLY;
         swBack_ff <= 1'b0;
         tgt_ff    <= 1'b0;
         sel_ff    <= 1'b0;
      end else if (extResetReq || wdtResetReq) begin
         // Reset wakes from sleep; start-up only if osc was off
         state_ff  <= (sleeping && xtalMode) ? ST_OST : ST_RUN;
         swBack_ff <= 1'b0;
         tgt_ff    <= 1'b0;
         sel_ff    <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_PORDLY: if (cntDone) begin
               // Timer only when enabled; else straight on
               if (!powerupTimerEnFuseN) state_ff <= ST_POWERUP_TIMER;
               else state_ff <= xtalMode ? ST_OST : ST_RUN;
            end
            ST_POWERUP_TIMER: if (cntDone) begin
               state_ff <= xtalMode ? ST_OST : ST_RUN;
            end
            ST_OST: if (cntDone) begin
               if (hs4Mode) state_ff <= ST_PLL;
               else state_ff <= swBack_ff ? ST_SYNC : ST_RUN;
            end
            ST_PLL: if (cntDone) begin
               state_ff <= swBack_ff ? ST_SYNC : ST_RUN;
            end
            ST_SYNC: if (cntDone) begin
               state_ff  <= ST_RUN;
               sel_ff    <= tgt_ff;
               swBack_ff <= 1'b0;
            end
            ST_RUN: if (atQ1 && sleepReq) begin
               state_ff <= ST_SLEEP;
            end else if (atQ1 && scs_ff != sel_ff) begin
               tgt_ff <= scs_ff;
               if (scs_ff) begin
                  state_ff <= ST_SYNC;
               end else begin
                  swBack_ff <= 1'b1;
                  state_ff  <= xtalMode ? ST_OST : ST_SYNC;
               end
            end
            ST_SLEEP: if (wakeIrq) begin
               state_ff <= xtalMode ? ST_OST : ST_RUN;
            end
         endcase
      end
   end

   // Quarter phase advances on active source edges while running
   always_ff @(posedge clk) begin
      if (anyRst) begin
         phase_ff <= 2'h0;
      end else if (state_ff == ST_RUN && sysEdge && !(atQ1 && sleepReq) &&
                   !(atQ1 && scs_ff != sel_ff)) begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   assign coreRun      = (state_ff == ST_RUN);
   assign sysClkSel    = sel_ff;
   assign quarterPhase = phase_ff;
   assign oscRunning   = !sleeping;
   assign pllEnable    = hs4Mode && !sleeping;
   assign clockRatio   = pllEnable ? 3'(PLL_MULT) : 3'h1;
   assign feedbackAmpEn = xtalMode && !sleeping;

   // ****************************************
   // Clock output pin
   // ****************************************
   logic [1:0] div_ff;
   logic       pinOut_ff;
   logic       pinOe_ff;
   logic       pinIn_ff;

   // Divide the main input by four
   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_ff <= 2'h0;
      end else if (mainEdge) begin
         div_ff <= div_ff + 2'h1;
      end
   end

   // Pin drive per mode
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pinOut_ff <= 1'b0;
         pinOe_ff  <= 1'b0;
         pinIn_ff  <= 1'b0;
      end else begin
         pinIn_ff <= ioMode ? clockOutputPinIn : 1'b0;
         if (ioMode) begin
            pinOut_ff <= portABitSixOut;
            pinOe_ff  <= portABitSixOe;
         end else if (plainOut) begin
            pinOut_ff <= sleeping ? 1'b0 : div_ff[CLKOUT_DIV / 2 - 1];
            pinOe_ff  <= 1'b1;
         end else begin
            pinOut_ff <= 1'b0;
            pinOe_ff  <= 1'b0;
         end
      end
   end

   assign clockOutputPinOut = pinOut_ff;
   assign clockOutputPinOe  = pinOe_ff;
   assign portABitSixIn     = pinIn_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   extAmpOff_a: assert property (
      (oscSelectField == OSC_EC || oscSelectField == OSC_EXTERNAL_CLOCK_IO_MODE) |-> !feedbackAmpEn)
      else $error("amplifier on in external clock mode");
   ecWakeFast_a: assert property (
      (sleeping && wakeIrq && noRst && !xtalMode) |=> coreRun)
      else $error("start-up wait applied without crystal");
   clkOutDiv_a: assert property (
      (resetn && plainOut && !sleeping && noRst) |=> clockOutputPinOut == $past(div_ff[1]) && clockOutputPinOe)
      else $error("clock output not input divided by four");
   ioPass_a: assert property (
      (resetn && ioMode) |=> clockOutputPinOe == $past(portABitSixOe) && clockOutputPinOut == $past(portABitSixOut))
      else $error("pin not acting as port bit");
   pllOnlyHs_a: assert property (
      (pllEnable |-> hs4Mode) and (pllEnable |-> clockRatio == 3'h4))
      else $error("multiplier state wrong for mode");
   lockWait_a: assert property (
      (state_ff == ST_OST && cntDone && hs4Mode && noRst) |=> state_ff == ST_PLL && !coreRun)
      else $error("lock time-out skipped");
   scsForced_a: assert property (
      (!swAllowed && noRst) |=> !scs_ff)
      else $error("select bit not held at zero");
   scsReset_a: assert property (
      (extResetReq || wdtResetReq) |=> !scs_ff && !sysClkSel)
      else $error("reset did not clear select");
   oscRead_a: assert property (
      (psel && !penable && paddr == OSC_CTRL_OFS) |=> prdata[31:1] == 31'h0 && prdata[0] == $past(scs_ff))
      else $error("control read wrong");
   syncDone_a: assert property (
      (state_ff == ST_SYNC && cntDone && noRst) |=> coreRun && sysClkSel == $past(tgt_ff))
      else $error("handover after eight edges failed");
   syncBound_a: assert property (
      state_ff == ST_SYNC |-> cnt_ff < CNT_W'(SYNC_EDGES))
      else $error("edge count overran");
   freezeQ1_a: assert property (
      ($fell(coreRun) && noRst && $past(noRst)) |-> quarterPhase == 2'h0)
      else $error("core not frozen at first quarter");
   sleepOff_a: assert property (
      sleeping |-> !oscRunning && !feedbackAmpEn && quarterPhase == 2'h0)
      else $error("clocks running in sleep");
   sleepPin_a: assert property (
      (sleeping && plainOut) |=> !clockOutputPinOut)
      else $error("clock output not low in sleep");

   toSec_c: cover property (state_ff == ST_SYNC && cntDone && tgt_ff);
   toMain_c: cover property (state_ff == ST_SYNC && cntDone && !tgt_ff);
   sleepWake_c: cover property (sleeping ##1 !sleeping);
   pllBoot_c: cover property (state_ff == ST_PLL && cntDone && !swBack_ff);

endmodule

// [logic/scs_pkg.sv]
// Constants, register map and state type for the system clock source switch
package scs_pkg;

   // ****************************************
   // Oscillator select field encodings
   // ****************************************
   localparam logic [2:0] OSC_LP   = 3'h0;  // Low-power crystal
   localparam logic [2:0] OSC_XT   = 3'h1;  // Standard crystal
   localparam logic [2:0] OSC_HS   = 3'h2;  // High-speed crystal
   localparam logic [2:0] OSC_RC   = 3'h3;  // Resistor-capacitor
   localparam logic [2:0] OSC_EC   = 3'h4;  // External clock
   localparam logic [2:0] OSC_EXTERNAL_CLOCK_IO_MODE = 3'h5;  // External clock, pin is I/O
   localparam logic [2:0] OSC_HS4  = 3'h6;  // High-speed with multiplier
   localparam logic [2:0] OSC_RESISTOR_CAPACITOR_IO_MODE = 3'h7;  // RC, pin is I/O

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [11:0] OSC_CTRL_OFS = 12'h000;  // oscillator_control
   localparam logic [11:0] TMR_CTRL_OFS = 12'h004;  // secondary_timer_control
   localparam logic [11:0] STATUS_OFS   = 12'h008;  // Switch status
   localparam int          SCS_BIT      = 0;        // Clock source select
   localparam int          SECEN_BIT    = 0;        // Secondary osc enable
   localparam int          PORT_A_A_IO_BIT = 6;        // Port A bit of the pin
   localparam logic [7:0]  OSC_CTRL_RST = 8'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ      = 10_000_000;
   localparam int POWERUP_TIMER_MS     = 72;
   localparam int POWERUP_TIMER_CYC    = POWERUP_TIMER_MS * (CLK_HZ / 1000);
   localparam int LOCK_TIME_OUT_MS     = 2;
   localparam int LOCK_TIME_OUT_CYC    = LOCK_TIME_OUT_MS * (CLK_HZ / 1000);
   localparam int POR_DLY_CYC = 16;    // Reset delay ahead of the timer
   localparam int OST_EDGES   = 1024;  // Clock input edges of start-up
   localparam int SYNC_EDGES  = 8;     // Target edges before a handover
   localparam int PLL_MULT    = 4;
   localparam int CLKOUT_DIV  = 4;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      ST_PORDLY, ST_POWERUP_TIMER, ST_OST, ST_PLL, ST_SYNC, ST_RUN, ST_SLEEP
   } scs_state_e;

endpackage

// [sim/scs_osc_model.sv]
// Free-running main and secondary oscillator sources
`timescale 1ns/100ps

module scs_osc_model #(
   parameter int MAIN_HALF_NS = 312,  // Main source half period
   parameter int SEC_HALF_NS  = 532   // Secondary source half period
) (
   output logic mainClk,  // Main source level
   output logic secClk    // Secondary source level
);
   // Both sources run at all times, unrelated to the system clock
   // Half periods are multiples of four ns, so no edge meets a system clock rising edge
   initial mainClk = 1'b0;
   initial secClk = 1'b0;
   always #(MAIN_HALF_NS) mainClk = ~mainClk;
   always #(SEC_HALF_NS) secClk = ~secClk;
endmodule

// [sim/scs_clock_switch_tb.sv]
// Self-checking bench for the clock source switch
`timescale 1ns/100ps

module scs_clock_switch_tb;
   import scs_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err;
   logic [2:0]  oscSel = OSC_EC;
   logic        swFuseN = 1'b1;
   logic        pwrtFuseN = 1'b1;
   logic        borEvent = 1'b0;
   logic        extRst = 1'b0;
   logic        porEvt = 1'b0;
   logic        wdtRst = 1'b0;
   logic        wakeIrq = 1'b0;
   logic        sleepReq = 1'b0;
   logic        portOut = 1'b0;
   logic        portOe = 1'b0;
   logic        padPull = 1'b0;
   logic        mainClk, secClk, portIn, pinOut, pinOe, coreRun, sysClkSel, pllEnable, ampEn, oscRunning;
   logic [1:0]  quarterPhase;
   logic [2:0]  clockRatio;
   int          n;
   int          miscompares = 0;
   int          checked = 0;
   wire         pinLevel = pinOe ? pinOut : padPull;  // Pad level seen back

   // ****************************************
   // Clock, sources and design
   // ****************************************
   always #50 clk = ~clk;
   scs_osc_model u_scs_osc_model (.mainClk(mainClk), .secClk(secClk));
   scs_clock_switch #(.POWERUP_TIMER_CYCLES(50), .PLL_CYCLES(30)) u_scs_clock_switch (
      .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscSelectField(oscSel),
      .switchEnableFuseN(swFuseN), .powerupTimerEnFuseN(pwrtFuseN), .porEvent(porEvt), .borEvent(borEvent),
      .extResetReq(extRst), .wdtResetReq(wdtRst), .wakeIrq(wakeIrq), .sleepReq(sleepReq),
      .clockInputPin(mainClk), .secOscPin(secClk), .portABitSixOut(portOut), .portABitSixOe(portOe),
      .portABitSixIn(portIn), .clockOutputPinIn(pinLevel), .clockOutputPinOut(pinOut),
      .clockOutputPinOe(pinOe), .coreRun(coreRun), .sysClkSel(sysClkSel), .quarterPhase(quarterPhase),
      .pllEnable(pllEnable), .clockRatio(clockRatio), .feedbackAmpEn(ampEn), .oscRunning(oscRunning));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);  // Only the watchdog ends a hang
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic waitRun(input logic v);
      n = 0;
      while (coreRun !== v && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk("run wait bound", 32'(n < 20000), 32'h1);
   endtask

   task automatic boot(input logic [2:0] m, input logic pN);
      @(posedge clk);
      resetn <= 1'b0;
      oscSel <= m;
      pwrtFuseN <= pN;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      waitRun(1'b1);
   endtask

   task automatic setSrc(input logic v);
      apb(1'b1, OSC_CTRL_OFS, {31'h0, v});
      waitRun(1'b0);
      waitRun(1'b1);
   endtask

   // Input rising edges between two rising edges of the output pin
   task automatic divCount;
      int  c;
      bit  go;
      logic po, pi;
      c = 0;
      go = 0;
      po = pinOut;
      pi = mainClk;
      for (int k = 0; k < 400; k++) begin
         @(posedge clk);
         if (go && mainClk && !pi) c++;
         if (pinOut && !po && go) break;
         if (pinOut && !po) go = 1;
         po = pinOut;
         pi = mainClk;
      end
      chk("output divide", c, 32'h4);
   endtask

   task automatic final_report;
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      #8_000_000;
      miscompares++;
      final_report();
   end

   initial begin
      boot(OSC_EC, 1'b1);
      chk("boot time", 32'(n < 40), 32'h1);
      chk("amplifier", ampEn, 32'h0);
      chk("ratio", clockRatio, 32'h1);
      apb(1'b0, OSC_CTRL_OFS, 32'h0);
      chk("select after reset", rd, 32'h0);
      apb(1'b1, OSC_CTRL_OFS, 32'hFF);
      apb(1'b0, OSC_CTRL_OFS, 32'h0);
      chk("select fuse off", rd, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped error", err, 32'h1);
      chk("pin drive", pinOe, 32'h1);
      divCount();
      sleepReq <= 1'b1;
      for (int k = 0; oscRunning !== 1'b0 && k < 60; k++) @(posedge clk);
      sleepReq <= 1'b0;
      repeat (3) @(posedge clk);
      chk("sleep pin", {pinOe, pinOut}, 32'h2);
      chk("sleep core", {coreRun, oscRunning, quarterPhase}, 32'h0);
      wakeIrq <= 1'b1;
      @(posedge clk);
      wakeIrq <= 1'b0;
      waitRun(1'b1);
      chk("wake time", 32'(n < 5), 32'h1);
      $display("external clock test done");

      swFuseN <= 1'b0;
      boot(OSC_EXTERNAL_CLOCK_IO_MODE, 1'b0);
      chk("timer boot", 32'(n >= 66), 32'h1);
      portOe <= 1'b1;
      portOut <= 1'b1;
      repeat (3) @(posedge clk);
      chk("port drive", {pinOe, pinOut}, 32'h3);
      portOe <= 1'b0;
      padPull <= 1'b1;
      repeat (3) @(posedge clk);
      chk("port input", {pinOe, portIn}, 32'h1);
      apb(1'b1, TMR_CTRL_OFS, 32'h0);
      apb(1'b1, OSC_CTRL_OFS, 32'h1);
      apb(1'b0, OSC_CTRL_OFS, 32'h0);
      chk("select no secondary", {sysClkSel, rd[0]}, 32'h0);
      apb(1'b1, TMR_CTRL_OFS, 32'h1);
      setSrc(1'b1);
      chk("to secondary time", 32'(n >= 70), 32'h1);
      apb(1'b0, OSC_CTRL_OFS, 32'h0);
      chk("on secondary", {sysClkSel, rd[0]}, 32'h3);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status", {err, rd[5:0]}, 32'h23);
      setSrc(1'b0);
      chk("to main time", 32'(n >= 40 && n < 80), 32'h1);
      chk("on main", sysClkSel, 32'h0);
      setSrc(1'b1);
      extRst <= 1'b1;
      @(posedge clk);
      extRst <= 1'b0;
      apb(1'b0, OSC_CTRL_OFS, 32'h0);
      chk("reset clears select", {sysClkSel, rd[0]}, 32'h0);
      setSrc(1'b1);
      wdtRst <= 1'b1;
      @(posedge clk);
      wdtRst <= 1'b0;
      @(posedge clk);
      chk("watchdog clears select", {sysClkSel, coreRun}, 32'h1);
      $display("secondary source test done");

      boot(OSC_HS4, 1'b1);
      chk("lock boot", 32'(n > 6000), 32'h1);
      chk("multiplier", {pllEnable, clockRatio}, 32'hC);
      borEvent <= 1'b1;
      @(posedge clk);
      borEvent <= 1'b0;
      waitRun(1'b0);
      waitRun(1'b1);
      chk("brown-out boot", 32'(n > 6000), 32'h1);
      porEvt <= 1'b1;
      @(posedge clk);
      porEvt <= 1'b0;
      waitRun(1'b0);
      waitRun(1'b1);
      chk("power-on boot", 32'(n > 6000), 32'h1);
      $display("multiplier test done");

      boot(OSC_HS, 1'b1);
      chk("start-up boot", 32'(n > 6000), 32'h1);
      chk("no multiplier", {pllEnable, clockRatio}, 32'h1);
      apb(1'b1, TMR_CTRL_OFS, 32'h1);
      setSrc(1'b1);
      setSrc(1'b0);
      chk("crystal return", 32'(n > 6000), 32'h1);
      $display("crystal test done");

      boot(OSC_RC, 1'b1);
      chk("rc boot", 32'(n < 40), 32'h1);
      chk("rc pin drive", {pinOe, ampEn}, 32'h2);
      $display("rc test done");
      final_report();
   end
endmodule
